// >>> core/dsd_cond_eval.sv
// Condition code evaluator against the current flags
`timescale 1ns/100ps
`default_nettype none
module dsd_cond_eval
    import dsd_pkg::*;
(
    input  wire logic [3:0] cond,
    input  wire logic [7:0] flags,
    input  wire logic       has_cc,
    output logic            cond_true
);
    logic hit;

    // Code table: 0 false, odd/even pairs true/negated
    always_comb
    begin
        case (cond)
            4'h0:    hit = 1'b0;
            4'h1:    hit = flags[FL_C];
            4'h2:    hit = !flags[FL_C];
            4'h3:    hit = flags[FL_Z];
            4'h4:    hit = !flags[FL_Z];
            4'h5:    hit = flags[FL_N];
            4'h6:    hit = !flags[FL_N];
            4'h7:    hit = flags[FL_OV];
            4'h8:    hit = !flags[FL_OV];
            4'h9:    hit = flags[FL_IE];
            4'hA:    hit = !flags[FL_IE];
            4'hB:    hit = flags[FL_U0];
            4'hC:    hit = !flags[FL_U0];
            4'hD:    hit = flags[FL_U1];
            4'hE:    hit = !flags[FL_U1];
            default: hit = 1'b1;
        endcase
    end

    // No condition given means always true
    assign cond_true = !has_cc || hit;
endmodule : dsd_cond_eval
`default_nettype wire

// >>> core/dsd_decoder.sv
// Instruction decoder and sequencer with APB register access
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module dsd_decoder
    import dsd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy,
    output logic             exec_done,
    output logic             illegal_op,
    output logic             jump_taken,
    output logic             int_enable_flag,
    output logic             user_out_flag
);
    typedef enum logic {st_idle, st_run} dsd_state_t;

    logic        rst_m_q;
    logic        rst_s_n_q;
    dsd_state_t  st_q;
    logic [1:0]  cnt_q;
    logic [31:0] instr_q;
    logic [3:0]  cond_q;
    logic [7:0]  flags_q;
    logic [15:0] acc_q;
    logic [15:0] memptr_q;
    dsd_op_t     op_q;
    logic        mwalk_q;
    logic        ill_q;
    logic        ok_q;
    logic        bank_q;
    logic [1:0]  words_q;
    logic [1:0]  cyc_q;
    logic        wr_en;
    logic        issue_ok;
    logic        finish;
    logic        cond_ok;
    logic        mapped;
    dsd_op_t     op_d;
    dsd_mode_t   dm_d;
    dsd_mode_t   sm_d;
    logic [3:0]  dr_d;
    logic [3:0]  sr_d;
    logic        ill_d;
    logic        bank_d;
    logic [1:0]  cyc_d;
    logic [1:0]  words_d;
    logic [15:0] acc_new;
    logic        c_new;

    //-------------------------------------------------------------------
    // Decode helpers
    //-------------------------------------------------------------------
    function automatic logic is_acc_op(input dsd_op_t op);
        return op inside {absolute_value_op, increment_op, decrement_op,
            negate_op, rotate_left_op, rotate_right_op,
            arith_right_shift_op, logic_left_shift_op};
    endfunction

    function automatic logic is_mul_op(input dsd_op_t op);
        return op inside {multiply_load_op, multiply_add_op,
            multiply_subtract_op};
    endfunction

    function automatic logic is_alu_op(input dsd_op_t op);
        return op inside {add_op, and_op, or_op, xor_op, subtract_op,
            compare_op};
    endfunction

    // Operand legality for one descriptor
    function automatic logic legal(input dsd_op_t op, input dsd_mode_t dm,
        input dsd_mode_t sm, input logic [3:0] dr, input logic [3:0] sr,
        input logic b1, input logic b2, input logic cc);
        logic ok;
        ok = 1'b1;
        if (cc && !(is_acc_op(op) || op == jump_op || op == call_op))
            ok = 1'b0;
        if (is_acc_op(op) && dm != md_acc)
            ok = 1'b0;
        if (op == load_op)
        begin
            if (dm == md_hw_reg && dr == HW_PRODUCT)
                ok = 1'b0;
            if (dm == md_hw_reg && sm == md_hw_reg &&
                ((dr[3] && sr[3]) || (dr == HW_MULT_X && sr == HW_MULT_X) ||
                 (dr == HW_STATUS && sr == HW_STATUS)))
                ok = 1'b0;
            if (sm == md_acc_ind &&
                (dm == md_acc || (dm == md_hw_reg && dr == HW_ACC)))
                ok = 1'b0;
        end
        if (is_mul_op(op))
        begin
            if (sm != md_ram_ind || b2)
                ok = 1'b0;
            if (dm == md_ram_ind && !b1)
                ok = 1'b0;
            if (dm == md_hw_reg && dr == HW_MULT_X)
                ok = 1'b0;
            if (!(dm == md_ram_ind || dm == md_hw_reg))
                ok = 1'b0;
        end
        if (op == pop_op && !(dm inside {md_ptr_reg, md_data_reg,
            md_ram_ind, md_hw_reg, md_acc}))
            ok = 1'b0;
        if (op == push_op && !(sm inside {md_ptr_reg, md_data_reg,
            md_ram_ind, md_hw_reg, md_acc, md_long_imm, md_acc_ind,
            md_prog_ind}))
            ok = 1'b0;
        return ok;
    endfunction

    // Cycle count of a descriptor
    function automatic logic [1:0] cycles(input dsd_op_t op,
        input dsd_mode_t sm);
        logic [1:0] c;
        c = CYC_ONE;
        if (op inside {jump_op, call_op, subroutine_return_op})
            c = CYC_TWO;
        else if (sm == md_long_imm)
            c = CYC_TWO;
        else if (sm inside {md_prog_ind, md_acc_ind})
            c = CYC_THREE;
        return c;
    endfunction

    //-------------------------------------------------------------------
    // Reset release
    //-------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_m_q   <= 1'b0;
            rst_s_n_q <= 1'b0;
        end
        else
        begin
            rst_m_q   <= 1'b1;
            rst_s_n_q <= rst_m_q;
        end
    end

    //-------------------------------------------------------------------
    // Combinational decode
    //-------------------------------------------------------------------
    assign op_d = dsd_op_t'(instr_q[IN_OP +: 5]);
    assign dm_d = dsd_mode_t'(instr_q[IN_DMODE +: 4]);
    assign sm_d = dsd_mode_t'(instr_q[IN_SMODE +: 4]);
    assign dr_d = instr_q[IN_DREG +: 4];
    assign sr_d = instr_q[IN_SREG +: 4];
    assign ill_d = !legal(op_d, dm_d, sm_d, dr_d, sr_d, instr_q[IN_BANK1],
                          instr_q[IN_BANK2], instr_q[IN_HASCC]);
    assign cyc_d = cycles(op_d, sm_d);
    assign words_d = (op_d inside {jump_op, call_op} ||
        sm_d == md_long_imm) ? CYC_TWO : CYC_ONE;

    // Explicit switch, else on for a RAM-indirect destination
    assign bank_d = instr_q[IN_BSGIV] ? instr_q[IN_BSVAL] :
                    (dm_d == md_ram_ind);

    dsd_cond_eval u_cond (
        .cond      (cond_q),
        .flags     (flags_q),
        .has_cc    (instr_q[IN_HASCC]),
        .cond_true (cond_ok)
    );

    // Bus strobes and sequence events
    assign wr_en    = psel && penable && pready && pwrite;
    assign issue_ok = wr_en && paddr == OFS_CTRL && pwdata[0] &&
                      st_q == st_idle;
    assign finish   = st_q == st_run && cnt_q == 2'h0;
    assign mapped   = paddr inside {OFS_CTRL, OFS_INSTR, OFS_COND,
        OFS_FLAGS, OFS_RESULT, OFS_ACC, OFS_MEMPTR};

    //-------------------------------------------------------------------
    // APB slave
    //-------------------------------------------------------------------
    // Ready one cycle after setup, read data captured then
    always_ff @(posedge core_clk or negedge rst_s_n_q)
    begin
        if (!rst_s_n_q)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    OFS_CTRL:   prdata <= {31'h0, busy};
                    OFS_INSTR:  prdata <= instr_q;
                    OFS_COND:   prdata <= {28'h0, cond_q};
                    OFS_FLAGS:  prdata <= {24'h0, flags_q};
                    OFS_RESULT: prdata <= {25'h0, bank_q, cyc_q, words_q,
                                           !ok_q, ill_q};
                    OFS_ACC:    prdata <= {16'h0, acc_q};
                    OFS_MEMPTR: prdata <= {16'h0, memptr_q};
                    default:    prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Descriptor and condition registers
    always_ff @(posedge core_clk or negedge rst_s_n_q)
    begin
        if (!rst_s_n_q)
        begin
            instr_q <= 32'h0000_0000;
            cond_q  <= 4'h0;
        end
        else if (wr_en && paddr == OFS_INSTR)
            instr_q <= pwdata;
        else if (wr_en && paddr == OFS_COND)
            cond_q  <= pwdata[3:0];
    end

    //-------------------------------------------------------------------
    // Sequencer
    //-------------------------------------------------------------------
    // Run for the decoded cycle count, then finish
    always_ff @(posedge core_clk or negedge rst_s_n_q)
    begin
        if (!rst_s_n_q)
        begin
            st_q  <= st_idle;
            cnt_q <= 2'h0;
        end
        else
        begin
            case (st_q)
                st_idle:
                    if (issue_ok)
                    begin
                        st_q  <= st_run;
                        cnt_q <= cyc_d - CYC_ONE;
                    end
                st_run:
                    if (cnt_q == 2'h0)
                        st_q <= st_idle;
                    else
                        cnt_q <= cnt_q - 2'h1;
                default: st_q <= st_idle;
            endcase
        end
    end

    // Latched decode results of the issued instruction
    always_ff @(posedge core_clk or negedge rst_s_n_q)
    begin
        if (!rst_s_n_q)
        begin
            op_q    <= no_op;
            ill_q   <= 1'b0;
            ok_q    <= 1'b1;
            bank_q  <= 1'b0;
            words_q <= CYC_ONE;
            cyc_q   <= CYC_ONE;
            mwalk_q <= 1'b0;
        end
        else if (issue_ok)
        begin
            op_q    <= op_d;
            ill_q   <= ill_d;
            ok_q    <= cond_ok && !ill_d;
            bank_q  <= is_mul_op(op_d) && bank_d;
            words_q <= words_d;
            cyc_q   <= cyc_d;
            mwalk_q <= sm_d == md_prog_ind;
        end
    end

    // Status outputs
    always_ff @(posedge core_clk or negedge rst_s_n_q)
    begin
        if (!rst_s_n_q)
        begin
            busy       <= 1'b0;
            exec_done  <= 1'b0;
            illegal_op <= 1'b0;
            jump_taken <= 1'b0;
        end
        else
        begin
            busy       <= issue_ok || (st_q == st_run && !finish);
            exec_done  <= finish;
            illegal_op <= finish && ill_q;
            jump_taken <= finish && ok_q && op_q inside
                {jump_op, call_op, subroutine_return_op};
        end
    end

    //-------------------------------------------------------------------
    // Execution effects
    //-------------------------------------------------------------------
    // Accumulator unary operations
    always_comb
    begin
        acc_new = acc_q;
        c_new   = flags_q[FL_C];
        case (op_q)
            absolute_value_op: acc_new = acc_q[15] ? 16'h0 - acc_q : acc_q;
            increment_op:      acc_new = acc_q + 16'h1;
            decrement_op:      acc_new = acc_q - 16'h1;
            negate_op:         acc_new = 16'h0 - acc_q;
            rotate_left_op:    acc_new = {acc_q[14:0], acc_q[15]};
            rotate_right_op:   acc_new = {acc_q[0], acc_q[15:1]};
            arith_right_shift_op:
            begin
                acc_new = {acc_q[15], acc_q[15:1]};
                c_new   = acc_q[0];
            end
            logic_left_shift_op:
            begin
                acc_new = {acc_q[14:0], 1'b0};
                c_new   = acc_q[15];
            end
            default: acc_new = acc_q;
        endcase
    end

    // Accumulator: finish wins over a bus write
    always_ff @(posedge core_clk or negedge rst_s_n_q)
    begin
        if (!rst_s_n_q)
            acc_q <= ACC_RST;
        else if (finish && ok_q && is_acc_op(op_q))
            acc_q <= acc_new;
        else if (wr_en && paddr == OFS_ACC)
            acc_q <= pwdata[15:0];
    end

    // Flags: hardware set or clear overrides a bus write
    always_ff @(posedge core_clk or negedge rst_s_n_q)
    begin
        if (!rst_s_n_q)
            flags_q <= FLAGS_RST;
        else if (finish && ok_q)
        begin
            case (op_q)
                carry_set_op:           flags_q[FL_C]  <= 1'b1;
                carry_clear_op:         flags_q[FL_C]  <= 1'b0;
                int_enable_set_op:      flags_q[FL_IE] <= 1'b1;
                int_enable_clear_op:    flags_q[FL_IE] <= 1'b0;
                user_out_flag_set_op:   flags_q[FL_OP] <= 1'b1;
                user_out_flag_clear_op: flags_q[FL_OP] <= 1'b0;
                default:
                    if (is_acc_op(op_q))
                    begin
                        flags_q[FL_C] <= c_new;
                        flags_q[FL_Z] <= acc_new == 16'h0;
                        flags_q[FL_N] <= acc_new[15];
                    end
            endcase
        end
        else if (wr_en && paddr == OFS_FLAGS)
            flags_q <= pwdata[7:0];
    end

    // RAM-held program address walks forward
    always_ff @(posedge core_clk or negedge rst_s_n_q)
    begin
        if (!rst_s_n_q)
            memptr_q <= 16'h0000;
        else if (finish && ok_q && mwalk_q)
            memptr_q <= memptr_q + 16'h1;
        else if (wr_en && paddr == OFS_MEMPTR)
            memptr_q <= pwdata[15:0];
    end

    // Flag outputs
    always_ff @(posedge core_clk or negedge rst_s_n_q)
    begin
        if (!rst_s_n_q)
        begin
            int_enable_flag <= 1'b0;
            user_out_flag   <= 1'b0;
        end
        else
        begin
            int_enable_flag <= flags_q[FL_IE];
            user_out_flag   <= flags_q[FL_OP];
        end
    end

    //-------------------------------------------------------------------
    // Assertions
    //-------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_s_n_q);

    property p_acc_one;
        issue_ok && is_acc_op(op_d) |-> ##2 exec_done;
    endproperty
    a_acc_one: assert property (p_acc_one)
        else $error("acc op not done in one cycle");

    property p_limm_two;
        issue_ok && sm_d == md_long_imm && !ill_d |=>
            !exec_done ##1 !exec_done ##1 (exec_done && words_q == 2'h2);
    endproperty
    a_limm_two: assert property (p_limm_two)
        else $error("long immediate timing wrong");

    property p_prog_three;
        issue_ok && sm_d inside {md_prog_ind, md_acc_ind} &&
            !(op_d inside {jump_op, call_op, subroutine_return_op}) |=>
            (!exec_done)[*3] ##1 exec_done;
    endproperty
    a_prog_three: assert property (p_prog_three)
        else $error("program indirect not three cycles");

    property p_branch_two;
        issue_ok && op_d inside {jump_op, call_op, subroutine_return_op}
            |-> ##3 exec_done;
    endproperty
    a_branch_two: assert property (p_branch_two)
        else $error("branch not two cycles");

    property p_ld_product;
        issue_ok && op_d == load_op && dm_d == md_hw_reg &&
            dr_d == HW_PRODUCT && cyc_d == CYC_ONE |=>
            ill_q ##[1:1] illegal_op;
    endproperty
    a_ld_product: assert property (p_ld_product)
        else $error("product destination accepted");

    property p_mul_one;
        issue_ok && is_mul_op(op_d) && !ill_d |-> ##2 exec_done;
    endproperty
    a_mul_one: assert property (p_mul_one)
        else $error("multiply not one cycle");

    property p_mul_bank;
        issue_ok && is_mul_op(op_d) && !instr_q[IN_BSGIV] |=>
            bank_q == $past(dm_d == md_ram_ind);
    endproperty
    a_mul_bank: assert property (p_mul_bank)
        else $error("default bank switch wrong");

    property p_false_keeps;
        exec_done && !ok_q && !$past(wr_en) |->
            acc_q == $past(acc_q, 1) &&
            flags_q == $past(flags_q, 1);
    endproperty
    a_false_keeps: assert property (p_false_keeps)
        else $error("false condition changed state");

    property p_walk;
        exec_done && ok_q && mwalk_q |-> memptr_q == $past(memptr_q) + 16'h1;
    endproperty
    a_walk: assert property (p_walk)
        else $error("program address not incremented");

    c_mul: cover property (issue_ok && is_mul_op(op_d) && !ill_d);
    c_false: cover property (exec_done && !ok_q && !ill_q);
    c_illegal: cover property (illegal_op);
endmodule : dsd_decoder
`default_nettype wire

// >>> core/dsd_pkg.sv
// Package for the signal processor instruction decoder and sequencer
//-----------------------------------------------------------------------
//-----------------------------------------------------------------------
package dsd_pkg;
    // Instruction opcodes
    typedef enum logic [4:0] {
        no_op, absolute_value_op, increment_op, decrement_op, negate_op,
        rotate_left_op, rotate_right_op, arith_right_shift_op,
        logic_left_shift_op, add_op, and_op, or_op, xor_op, subtract_op,
        compare_op, load_op, push_op, pop_op, jump_op, call_op,
        subroutine_return_op, multiply_load_op, multiply_add_op,
        multiply_subtract_op, carry_set_op, carry_clear_op,
        int_enable_set_op, int_enable_clear_op, user_out_flag_set_op,
        user_out_flag_clear_op
    } dsd_op_t;

    // Operand addressing modes
    typedef enum logic [3:0] {
        md_none, md_acc, md_ptr_reg, md_data_reg, md_hw_reg, md_long_imm,
        md_short_imm, md_ram_ind, md_prog_ind, md_acc_ind, md_direct
    } dsd_mode_t;

    // Hardware register codes
    localparam logic [3:0] HW_BUS      = 4'h0;
    localparam logic [3:0] HW_MULT_X   = 4'h1;
    localparam logic [3:0] HW_ACC      = 4'h3;
    localparam logic [3:0] HW_STATUS   = 4'h4;
    localparam logic [3:0] HW_PRODUCT  = 4'h7;
    localparam logic [3:0] HW_EXT_BASE = 4'h8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_INSTR  = 8'h04;
    localparam logic [7:0] OFS_COND   = 8'h08;
    localparam logic [7:0] OFS_FLAGS  = 8'h0C;
    localparam logic [7:0] OFS_RESULT = 8'h10;
    localparam logic [7:0] OFS_ACC    = 8'h14;
    localparam logic [7:0] OFS_MEMPTR = 8'h18;

    // Instruction descriptor field positions
    localparam int IN_OP    = 0;
    localparam int IN_DMODE = 8;
    localparam int IN_SMODE = 12;
    localparam int IN_DREG  = 16;
    localparam int IN_SREG  = 20;
    localparam int IN_BANK1 = 24;
    localparam int IN_BANK2 = 25;
    localparam int IN_BSGIV = 26;
    localparam int IN_BSVAL = 27;
    localparam int IN_HASCC = 28;

    // Flag bit positions
    localparam int FL_C  = 0;
    localparam int FL_Z  = 1;
    localparam int FL_N  = 2;
    localparam int FL_OV = 3;
    localparam int FL_IE = 4;
    localparam int FL_OP = 5;
    localparam int FL_U0 = 6;
    localparam int FL_U1 = 7;

    // Reset values and cycle counts
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [15:0] ACC_RST   = 16'h0000;
    localparam logic [1:0]  CYC_ONE   = 2'h1;
    localparam logic [1:0]  CYC_TWO   = 2'h2;
    localparam logic [1:0]  CYC_THREE = 2'h3;
endpackage : dsd_pkg

// >>> tb/dsd_apb_bfm.sv
// APB requester model that stands on the far side of the decoder
`timescale 1ns/100ps
`default_nettype none
module dsd_apb_bfm
(
    input  wire logic        core_clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Setup cycle, then access held until pready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
endmodule // dsd_apb_bfm
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dsd_pkg::*;
    logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        busy, exec_done, illegal_op, jump_taken;
    logic        int_enable_flag, user_out_flag;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, seed, r;
    logic [32:0] rd_q[$];
    logic [3:0]  cyc_q[$], n;
    int          errors, total_checks, cnt;
    // Result byte and descriptor for each instruction
    logic [39:0] tbl [15] = '{
        40'h14_00000104,
        40'h28_00000012,
        40'h17_0011440F,
        40'h37_0000910F,
        40'h54_01007715,
        40'h14_00037415,
        40'h14_05007716,
        40'h17_00017417,
        40'h28_0000510F,
        40'h34_00008010,
        40'h24_00000014,
        40'h16_10000104,
        40'h17_0027440F,
        40'h14_00000018,
        40'h14_00000107};
    dsd_apb_bfm u_dsd_apb_bfm (.core_clk(core_clk), .pready(pready),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    dsd_decoder u_dsd_decoder (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy), .exec_done(exec_done),
        .illegal_op(illegal_op), .jump_taken(jump_taken),
        .int_enable_flag(int_enable_flag), .user_out_flag(user_out_flag));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string n, input logic [32:0] e,
                         input logic [32:0] s);
        total_checks++;
        if (s !== e)
        begin
            errors++;
            $display("unexpected %s exp=%h got=%h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("errors=%0d total_checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_dsd_apb_bfm.xfer(1'b1, a, d, rd);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        u_dsd_apb_bfm.xfer(1'b0, a, 32'h0, rd);
    endtask
    task automatic run(input logic [39:0] t);
        wr(OFS_INSTR, t[31:0]);
        cyc_q.push_back({t[4:0] inside {5'h12, 5'h13, 5'h14} && !t[33],
                         t[32], t[37:36]});
        wr(OFS_CTRL, 32'h1);
        repeat (4) @(posedge core_clk);
        rdx(OFS_RESULT, {25'h0, t[39:32]});
    endtask
    // Monitor: read data and issue-to-done spacing
    always @(posedge core_clk)
    begin
        cnt <= cnt + 1;
        if (psel && penable && pready && pwrite && paddr === OFS_CTRL)
            cnt <= 1;
        if (psel && penable && pready && !pwrite)
            check("read", rd_q.pop_front(), {pslverr, prdata});
        if (exec_done === 1'b1)
        begin
            n = cyc_q.pop_front();
            check("cycles", 33'(n[1:0]) + 33'h1, 33'(cnt));
            check("illegal", 33'(n[2]), 33'(illegal_op));
            check("jump", 33'(n[3]), 33'(jump_taken));
            check("busy_end", 33'h0, 33'(busy));
        end
        if (cnt == 1 && rst_n === 1'b1)
            check("busy", 33'h1, 33'(busy));
    end
    initial
    begin
        #200000;
        errors++;
        close_out();
    end
    initial
    begin
        seed = 32'hBADA;
        cnt = 0;
        rst_n = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdx(OFS_FLAGS, {25'h0, FLAGS_RST});
        rdx(OFS_ACC, {17'h0, ACC_RST});
        rdx(8'h1C, {1'b1, 32'h0});
        wr(OFS_COND, 32'h0);
        for (int k = 0; k < 15; k++) run(tbl[k]);
        run(40'h34_0001940F);
        rdx(OFS_MEMPTR, {17'h0, 16'h0001});
        wr(OFS_COND, 32'hF);
        run(40'h28_10000013);
        r = xs();
        wr(OFS_ACC, r);
        rdx(OFS_ACC, {17'h0, r[15:0]});
        run(40'h14_00000102);
        rdx(OFS_ACC, {17'h0, r[15:0] + 16'h1});
        wr(OFS_FLAGS, xs());
        r = seed;
        run(40'h14_0000001A);
        run(40'h14_0000001C);
        rdx(OFS_FLAGS, {25'h0, r[7:0] | 8'h30});
        check("ie", 33'h1, 33'(int_enable_flag));
        check("uo", 33'h1, 33'(user_out_flag));
        close_out();
    end
endmodule // tb
`default_nettype wire
